// ===== inc/dcpa_regs.svh
// register offsets, field positions, request codes and peripheral addresses
`ifndef DCPA_REGS_SVH
`define DCPA_REGS_SVH

// channel count, index width, request source count and peripheral request line count
`define DCPA_NCH 4
`define DCPA_CHW 2
`define DCPA_NSRC 11
`define DCPA_NPERIPH 10

// register index within a channel, address = {channel, index}
`define DCPA_REG_SEL 2'h0
`define DCPA_REG_PAD 2'h1
`define DCPA_REG_CON 2'h2
`define DCPA_REG_DAT 2'h3

// control register bit positions
`define DCPA_CON_EN 0
`define DCPA_CON_DIR 1
`define DCPA_CON_TRIG 2

// reset values
`define DCPA_RST_SEL 8'h00
`define DCPA_RST_WORD 16'h0000

// request source slot in the request vector
`define DCPA_SRC_EXT0 0
`define DCPA_SRC_CAP2 1
`define DCPA_SRC_CAP3 2
`define DCPA_SRC_CMP2 3
`define DCPA_SRC_SER1RX 4
`define DCPA_SRC_SER1TX 5
`define DCPA_SRC_CAN1RX 6
`define DCPA_SRC_CAN1TX 7
`define DCPA_SRC_CODEC 8
`define DCPA_SRC_CONV1 9
`define DCPA_SRC_CONV2 10

// request source select codes
`define DCPA_CODE_EXT0 8'h00
`define DCPA_CODE_CAP2 8'h05
`define DCPA_CODE_CAP3 8'h25
`define DCPA_CODE_CMP2 8'h06
`define DCPA_CODE_SER1RX 8'h0B
`define DCPA_CODE_SER1TX 8'h0C
`define DCPA_CODE_CAN1RX 8'h22
`define DCPA_CODE_CAN1TX 8'h46
`define DCPA_CODE_CODEC 8'h3C
`define DCPA_CODE_CONV1 8'h0D
`define DCPA_CODE_CONV2 8'h15

// peripheral data addresses, readable set
`define DCPA_AD_CAPTURE2_BUFFER 16'h014C
`define DCPA_AD_CAPTURE3_BUFFER 16'h0154
`define DCPA_AD_SERIAL1_RX_HOLDING 16'h0226
`define DCPA_AD_CAN1_RX_WORD 16'h0440
`define DCPA_AD_CODEC_RX_SLOT0 16'h0290
`define DCPA_AD_CONVERTER1_RESULT0 16'h0300
`define DCPA_AD_CONVERTER2_RESULT0 16'h0340
// peripheral data addresses, writable set
`define DCPA_AD_COMPARE2_PRIMARY 16'h0910
`define DCPA_AD_COMPARE2_SECONDARY 16'h090E
`define DCPA_AD_SERIAL1_TX_HOLDING 16'h0224
`define DCPA_AD_CAN1_TX_WORD 16'h0442
`define DCPA_AD_CODEC_TX_SLOT0 16'h0298

`endif

// ===== inc/dcpa_pkg.sv
// types shared by the channel association block
package dcpa_pkg;
`include "dcpa_regs.svh"

	typedef logic [7:0] dcpa_sel_t;
	typedef logic [15:0] dcpa_word_t;
	typedef logic [`DCPA_CHW-1:0] dcpa_ch_t;
	typedef logic [`DCPA_NSRC-1:0] dcpa_src_t;

	// whole state of the top module
	typedef struct packed {
		dcpa_sel_t [`DCPA_NCH-1:0] sel;
		dcpa_word_t [`DCPA_NCH-1:0] pad;
		logic [`DCPA_NCH-1:0] en;
		logic [`DCPA_NCH-1:0] dir;
		logic [`DCPA_NCH-1:0] pend;
		dcpa_word_t [`DCPA_NCH-1:0] data;
		logic [1:0] ext_sync;
		logic ext_last;
		dcpa_word_t rdata;
		dcpa_word_t per_addr;
		dcpa_word_t per_wdata;
		logic per_rd;
		logic per_wr;
		logic done;
		logic xfer_cap;
		dcpa_ch_t xfer_ch;
	} dcpa_state_t;
endpackage : dcpa_pkg

// ===== inc/dcpa_dec_if.sv
// per-channel link between state and the association decoder
`timescale 1ns/1ns
interface dcpa_dec_if;
	dcpa_pkg::dcpa_sel_t sel;
	dcpa_pkg::dcpa_word_t addr;
	logic wr_dir;
	dcpa_pkg::dcpa_src_t src;
	logic addr_ok;

	modport dec (
		input sel,
		input addr,
		input wr_dir,
		output src,
		output addr_ok
	);
	modport user (
		output sel,
		output addr,
		output wr_dir,
		input src,
		input addr_ok
	);
endinterface : dcpa_dec_if

// ===== core/dcpa_decode.sv
// association decoder: request code to source slot, address to validity
`timescale 1ns/1ns
`include "dcpa_regs.svh"
module dcpa_decode (
	// channel settings in, decode out
	dcpa_dec_if.dec bus
);

	// one-hot source slot, unlisted codes give none
	function automatic dcpa_pkg::dcpa_src_t code_to_src(input dcpa_pkg::dcpa_sel_t code);
		dcpa_pkg::dcpa_src_t oh;
		oh = '0;
		case (code)
			`DCPA_CODE_EXT0: oh[`DCPA_SRC_EXT0] = 1'b1;
			`DCPA_CODE_CAP2: oh[`DCPA_SRC_CAP2] = 1'b1;
			`DCPA_CODE_CAP3: oh[`DCPA_SRC_CAP3] = 1'b1;
			`DCPA_CODE_CMP2: oh[`DCPA_SRC_CMP2] = 1'b1;
			`DCPA_CODE_SER1RX: oh[`DCPA_SRC_SER1RX] = 1'b1;
			`DCPA_CODE_SER1TX: oh[`DCPA_SRC_SER1TX] = 1'b1;
			`DCPA_CODE_CAN1RX: oh[`DCPA_SRC_CAN1RX] = 1'b1;
			`DCPA_CODE_CAN1TX: oh[`DCPA_SRC_CAN1TX] = 1'b1;
			`DCPA_CODE_CODEC: oh[`DCPA_SRC_CODEC] = 1'b1;
			`DCPA_CODE_CONV1: oh[`DCPA_SRC_CONV1] = 1'b1;
			`DCPA_CODE_CONV2: oh[`DCPA_SRC_CONV2] = 1'b1;
			default: oh = '0;
		endcase
		return oh;
	endfunction : code_to_src

	// address legal for the direction; external irq zero has no data register
	function automatic logic addr_valid(input dcpa_pkg::dcpa_word_t a, input logic wr);
		logic ok;
		ok = 1'b0;
		if (wr) begin
			case (a)
				`DCPA_AD_COMPARE2_PRIMARY, `DCPA_AD_COMPARE2_SECONDARY: ok = 1'b1;
				`DCPA_AD_SERIAL1_TX_HOLDING: ok = 1'b1;
				`DCPA_AD_CAN1_TX_WORD: ok = 1'b1;
				`DCPA_AD_CODEC_TX_SLOT0: ok = 1'b1;
				default: ok = 1'b0;
			endcase
		end else begin
			case (a)
				`DCPA_AD_CAPTURE2_BUFFER: ok = 1'b1;
				`DCPA_AD_CAPTURE3_BUFFER: ok = 1'b1;
				`DCPA_AD_SERIAL1_RX_HOLDING: ok = 1'b1;
				`DCPA_AD_CAN1_RX_WORD: ok = 1'b1;
				`DCPA_AD_CODEC_RX_SLOT0: ok = 1'b1;
				`DCPA_AD_CONVERTER1_RESULT0: ok = 1'b1;
				`DCPA_AD_CONVERTER2_RESULT0: ok = 1'b1;
				default: ok = 1'b0;
			endcase
		end
		return ok;
	endfunction : addr_valid

	// purely combinational decode
	assign bus.src = code_to_src(bus.sel);
	assign bus.addr_ok = addr_valid(bus.addr, bus.wr_dir);

endmodule : dcpa_decode

// ===== core/dcpa_top.sv
// channel to peripheral association: request routing, arbitration, access gating
//
// What this block does
// - select code all zeros takes requests from external irq zero, no data register.
// - code 00000101 triggers on capture unit 2; buffer read at 0x014C.
// - code 00100101 triggers on capture unit 3; buffer read at 0x0154.
// - code 00000110 triggers on compare unit 2; writes to 0x0910 or 0x090E.
// - code 00001011 triggers on serial1 receiver; holding register read at 0x0226.
// - code 00001100 triggers on serial1 transmitter; holding register written at 0x0224.
// - code 00100010 triggers on CAN1 receive ready; word read at 0x0440.
// - code 01000110 triggers on CAN1 transmit request; word written at 0x0442.
// - code 00111100 triggers on codec done; reads 0x0290, writes 0x0298.
// - code 00001101 triggers on converter1 done; result read at 0x0300.
// - code 00010101 triggers on converter2 done; result read at 0x0340.
// - address register picks the data register; select register picks the trigger.
// - one request reaches every channel selecting it in the same cycle.
// - shared request: higher priority channel goes first, others stay pending.
// - writes to an unsupported peripheral address are dropped.
// - reads from an unsupported peripheral address return zero.
// - manual trigger bit raises a request arbitrated like peripheral requests.
// - a received request stays latched until its channel is granted or disabled.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "dcpa_regs.svh"
module dcpa_top (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// register port
	input wire logic [`DCPA_CHW+1:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [15:0] o_reg_rdata,
	// request sources
	input wire logic i_external_irq_zero,
	input wire logic [`DCPA_NPERIPH-1:0] i_periph_req,
	// peripheral data port
	output logic [15:0] o_per_addr,
	output logic [15:0] o_per_wdata,
	output logic o_per_wr,
	output logic o_per_rd,
	input wire logic [15:0] i_per_rdata,
	// transfer status
	output logic o_xfer_done,
	output logic [`DCPA_CHW-1:0] o_xfer_ch,
	output logic [`DCPA_NCH-1:0] o_pending
);

	dcpa_pkg::dcpa_state_t r;
	dcpa_pkg::dcpa_state_t r_nxt;

	// decode results per channel
	dcpa_pkg::dcpa_src_t [`DCPA_NCH-1:0] src_oh;
	logic [`DCPA_NCH-1:0] addr_ok;

	// one decoder per channel; decode is stateless so duplication costs only gates
	genvar g;
	generate
		for (g = 0; g < `DCPA_NCH; g = g + 1) begin : g_dec
			dcpa_dec_if u_if ();
			assign u_if.sel = r.sel[g];
			assign u_if.addr = r.pad[g];
			assign u_if.wr_dir = r.dir[g];
			assign src_oh[g] = u_if.src;
			assign addr_ok[g] = u_if.addr_ok;
			dcpa_decode u_dec (
				.bus(u_if.dec)
			);
		end
	endgenerate

	// lowest channel index has the highest priority
	function automatic logic [`DCPA_CHW:0] pick(input logic [`DCPA_NCH-1:0] p);
		logic [`DCPA_CHW:0] res;
		res = '0;
		for (int i = `DCPA_NCH - 1; i >= 0; i--) begin
			if (p[i]) begin
				res = {1'b1, i[`DCPA_CHW-1:0]};
			end
		end
		return res;
	endfunction : pick

	// combinational helpers
	logic ext_edge;
	dcpa_pkg::dcpa_src_t req_vec;
	logic [`DCPA_CHW:0] win;
	logic [`DCPA_NCH-1:0] hit;
	logic [`DCPA_NCH-1:0] clr;
	dcpa_pkg::dcpa_ch_t wch;
	dcpa_pkg::dcpa_ch_t rch;

	// request vector: synchronised edge of the pin plus same-clock peripheral pulses
	assign ext_edge = r.ext_sync[1] & ~r.ext_last;
	assign req_vec = {i_periph_req, ext_edge};
	assign win = pick(r.pend);
	assign wch = win[`DCPA_CHW-1:0];
	assign rch = i_reg_addr[`DCPA_CHW+1:2];

	// each channel sees every request it selects in the same cycle
	always_comb begin
		for (int c = 0; c < `DCPA_NCH; c++) begin
			hit[c] = r.en[c] & (|(src_oh[c] & req_vec));
			clr[c] = win[`DCPA_CHW] && (wch == c[`DCPA_CHW-1:0]);
		end
	end

	// next state
	always_comb begin
		r_nxt = r;
		r_nxt.per_rd = 1'b0;
		r_nxt.per_wr = 1'b0;
		r_nxt.done = 1'b0;
		r_nxt.xfer_cap = 1'b0;

		// two-flop synchroniser; only the second stage feeds the edge detector
		r_nxt.ext_sync = {r.ext_sync[0], i_external_irq_zero};
		r_nxt.ext_last = r.ext_sync[1];

		// granted channel issues its access in the next cycle
		if (win[`DCPA_CHW]) begin
			r_nxt.per_addr = r.pad[wch];
			r_nxt.xfer_ch = wch;
			r_nxt.done = 1'b1;
			if (r.dir[wch]) begin
				r_nxt.per_wr = addr_ok[wch];
				r_nxt.per_wdata = r.data[wch];
			end else begin
				r_nxt.per_rd = addr_ok[wch];
				r_nxt.xfer_cap = 1'b1;
			end
		end

		// pending stays until granted; a new request in the grant cycle wins
		for (int c = 0; c < `DCPA_NCH; c++) begin
			r_nxt.pend[c] = hit[c] | (r.pend[c] & ~clr[c]);
		end

		// register writes
		if (i_reg_wr) begin
			case (i_reg_addr[1:0])
				`DCPA_REG_SEL: begin
					r_nxt.sel[rch] = i_reg_wdata[7:0];
				end
				`DCPA_REG_PAD: begin
					r_nxt.pad[rch] = i_reg_wdata;
				end
				`DCPA_REG_CON: begin
					r_nxt.en[rch] = i_reg_wdata[`DCPA_CON_EN];
					r_nxt.dir[rch] = i_reg_wdata[`DCPA_CON_DIR];
					// disabling drops a stale request; trigger sets it anew
					if (!i_reg_wdata[`DCPA_CON_EN]) begin
						r_nxt.pend[rch] = 1'b0;
					end
					if (i_reg_wdata[`DCPA_CON_TRIG] && i_reg_wdata[`DCPA_CON_EN]) begin
						r_nxt.pend[rch] = 1'b1;
					end
				end
				`DCPA_REG_DAT: begin
					r_nxt.data[rch] = i_reg_wdata;
				end
				default: begin
					r_nxt.data[rch] = r.data[rch];
				end
			endcase
		end

		// read capture in the strobe cycle itself; unsupported address reads zero
		if (r.xfer_cap) begin
			r_nxt.data[r.xfer_ch] = r.per_rd ? i_per_rdata : `DCPA_RST_WORD;
		end

		// register read, answered in the following cycle
		r_nxt.rdata = `DCPA_RST_WORD;
		if (i_reg_rd) begin
			case (i_reg_addr[1:0])
				`DCPA_REG_SEL: r_nxt.rdata = {8'h00, r.sel[rch]};
				`DCPA_REG_PAD: r_nxt.rdata = r.pad[rch];
				`DCPA_REG_CON: begin
					r_nxt.rdata[`DCPA_CON_EN] = r.en[rch];
					r_nxt.rdata[`DCPA_CON_DIR] = r.dir[rch];
					r_nxt.rdata[`DCPA_CON_TRIG] = r.pend[rch];
				end
				`DCPA_REG_DAT: r_nxt.rdata = r.data[rch];
				default: r_nxt.rdata = `DCPA_RST_WORD;
			endcase
		end
	end

	// state register
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	// outputs straight from flops
	assign o_reg_rdata = r.rdata;
	assign o_per_addr = r.per_addr;
	assign o_per_wdata = r.per_wdata;
	assign o_per_wr = r.per_wr;
	assign o_per_rd = r.per_rd;
	assign o_xfer_done = r.done;
	assign o_xfer_ch = r.xfer_ch;
	assign o_pending = r.pend;

endmodule : dcpa_top

// ===== verif/dcpa_top_asserts.sv
// port-level checks for the channel association block
`timescale 1ns/1ns
module dcpa_top_asserts (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// causes
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [9:0] i_periph_req,
	input wire logic i_external_irq_zero,
	// effects
	input wire logic [15:0] o_reg_rdata,
	input wire logic [15:0] o_per_addr,
	input wire logic o_per_wr,
	input wire logic o_per_rd,
	input wire logic o_xfer_done,
	input wire logic [1:0] o_xfer_ch,
	input wire logic [3:0] o_pending
);
	logic [3:0] pend_r;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	// pending set one edge back, so grants can be judged against it
	always_ff @(posedge i_core_clk) begin
		pend_r <= o_pending;
	end
	property p_rd_addr;
		o_per_rd |-> o_per_addr inside {16'h014C, 16'h0154, 16'h0226, 16'h0440, 16'h0290,
			16'h0300, 16'h0340};
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("read strobe at bad address");
	property p_wr_addr;
		o_per_wr |-> o_per_addr inside {16'h0910, 16'h090E, 16'h0224, 16'h0442, 16'h0298};
	endproperty
	a_wr_addr: assert property (p_wr_addr) else $error("write strobe at bad address");
	property p_strobe_done;
		(o_per_rd || o_per_wr) |-> o_xfer_done && !(o_per_rd && o_per_wr);
	endproperty
	a_strobe_done: assert property (p_strobe_done) else $error("strobe without grant");
	property p_grant_pend;
		o_xfer_done |-> pend_r[o_xfer_ch];
	endproperty
	a_grant_pend: assert property (p_grant_pend) else $error("grant without request");
	property p_grant_prio;
		o_xfer_done |-> (pend_r & ((4'h1 << o_xfer_ch) - 4'h1)) == 4'h0;
	endproperty
	a_grant_prio: assert property (p_grant_prio) else $error("lower priority won");
	property p_pend_clear;
		(pend_r & ~o_pending) != 4'h0 |-> $past(i_reg_wr) ||
			(o_xfer_done && (pend_r & ~o_pending) == (4'h1 << o_xfer_ch));
	endproperty
	a_pend_clear: assert property (p_pend_clear) else $error("request lost");
	property p_pend_rise;
		(o_pending & ~pend_r) != 4'h0 |-> $past(i_reg_wr) || $past(i_periph_req) != 10'h000 ||
			$past(i_external_irq_zero, 3);
	endproperty
	a_pend_rise: assert property (p_pend_rise) else $error("request from nowhere");
	property p_rdata_idle;
		!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule : dcpa_top_asserts

bind dcpa_top dcpa_top_asserts i_dcpa_top_asserts (.i_core_clk, .i_reset_n, .i_reg_wr,
	.i_reg_rd, .i_periph_req, .i_external_irq_zero, .o_reg_rdata, .o_per_addr, .o_per_wr,
	.o_per_rd, .o_xfer_done, .o_xfer_ch, .o_pending);

// ===== verif/dcpa_periph_model.sv
// far-side peripherals: request lines and data registers
`timescale 1ns/1ns
module dcpa_periph_model (
	// clock
	input wire logic i_core_clk,
	// data port from the block
	input wire logic [15:0] i_per_addr,
	input wire logic [15:0] i_per_wdata,
	input wire logic i_per_wr,
	input wire logic i_per_rd,
	output logic [15:0] o_per_rdata,
	// requests
	output logic [9:0] o_periph_req = 10'h000,
	output logic o_external_irq_zero = 1'b0
);
	int nrd = 0;
	int nwr = 0;
	logic [15:0] last_addr_r = 16'h0000;
	logic [15:0] last_data_r = 16'h0000;
	logic [15:0] noise_r = 16'h0000;
	// data only in the strobe cycle; a moving pattern catches late sampling
	assign o_per_rdata = i_per_rd ? ~i_per_addr : noise_r;
	// strobe counts and last write seen
	always @(posedge i_core_clk) begin
		noise_r <= noise_r + 16'h3C5B;
		if (i_per_rd) nrd <= nrd + 1;
		if (i_per_wr) begin
			nwr <= nwr + 1;
			last_addr_r <= i_per_addr;
			last_data_r <= i_per_wdata;
		end
	end
	// one-cycle pulse; line numbers above 9 raise the pin for four cycles
	task automatic fire(input int n);
		@(posedge i_core_clk);
		if (n > 9) o_external_irq_zero <= 1'b1;
		else o_periph_req <= 10'h001 << n;
		@(posedge i_core_clk);
		o_periph_req <= 10'h000;
		if (n > 9) fork
			begin
				repeat (3) @(posedge i_core_clk);
				o_external_irq_zero <= 1'b0;
			end
		join_none
	endtask : fire
endmodule : dcpa_periph_model

// ===== verif/dcpa_tb_top.sv
// self-checking bench for the channel association block
`timescale 1ns/1ns
module dcpa_tb_top;
	logic i_core_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [3:0] a_r = 4'h0;
	logic [15:0] d_r = 16'h0000;
	logic wr_r = 1'b0;
	logic rd_r = 1'b0;
	logic [15:0] rdata, per_addr, per_wdata, per_rdata;
	logic per_wr, per_rd, done, ext;
	logic [1:0] xch;
	logic [3:0] pend;
	logic [9:0] req;
	int miscompares = 0;
	int tests_run = 0;
	int ndone = 0;
	// code, request line, valid and direction, peripheral address
	// last two entries: unsupported write address, on capture unit 2 and on compare unit 2
	logic [31:0] assoc [15] = '{32'h00F01234, 32'h0502014C, 32'h25120154, 32'h06230910,
		32'h0623090E, 32'h0B320226, 32'h0C430224, 32'h22520440, 32'h46630442, 32'h3C720290,
		32'h3C730298, 32'h0D820300, 32'h15920340, 32'h05011234, 32'h06211234};
	always #5 i_core_clk = ~i_core_clk;
	// grant pulses seen, for the silent-source check
	always @(posedge i_core_clk) if (done === 1'b1) ndone++;
	dcpa_top i_dcpa_top (.i_core_clk, .i_reset_n, .i_reg_addr(a_r), .i_reg_wdata(d_r),
		.i_reg_wr(wr_r), .i_reg_rd(rd_r), .o_reg_rdata(rdata), .i_external_irq_zero(ext),
		.i_periph_req(req), .o_per_addr(per_addr), .o_per_wdata(per_wdata),
		.o_per_wr(per_wr), .o_per_rd(per_rd), .i_per_rdata(per_rdata), .o_xfer_done(done),
		.o_xfer_ch(xch), .o_pending(pend));
	dcpa_periph_model i_dcpa_periph_model (.i_core_clk, .i_per_addr(per_addr),
		.i_per_wdata(per_wdata), .i_per_wr(per_wr), .i_per_rd(per_rd),
		.o_per_rdata(per_rdata), .o_periph_req(req), .o_external_irq_zero(ext));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_core_clk);
		a_r <= a;
		d_r <= d;
		wr_r <= 1'b1;
		@(posedge i_core_clk);
		wr_r <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge i_core_clk);
		a_r <= a;
		rd_r <= 1'b1;
		@(posedge i_core_clk);
		rd_r <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd
	// next edge must carry a grant to channel ch and leave pending p
	task automatic grant(input logic [1:0] ch, input logic [3:0] p);
		@(posedge i_core_clk);
		#1 chk({13'h0000, done, xch}, {13'h0000, 1'b1, ch});
		chk({12'h000, pend}, {12'h000, p});
	endtask : grant
	task automatic t_regs;
		for (int i = 0; i < 16; i++) rd(4'(i), 16'h0000);
		wr(4'h0, 16'hFF05);
		rd(4'h0, 16'h0005);
		wr(4'h2, 16'hFFF3);
		rd(4'h2, 16'h0003);
		wr(4'h2, 16'h0000);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_assoc;
		logic [31:0] e;
		int r0, w0, n;
		foreach (assoc[k]) begin
			e = assoc[k];
			wr(4'h4, {8'h00, e[31:24]});
			wr(4'h5, e[15:0]);
			wr(4'h7, e[15:0]);
			wr(4'h6, {14'h0000, e[16], 1'b1});
			r0 = i_dcpa_periph_model.nrd;
			w0 = i_dcpa_periph_model.nwr;
			i_dcpa_periph_model.fire(int'(e[23:20]));
			n = 0;
			while (done !== 1'b1 && n < 20) begin
				@(posedge i_core_clk);
				#1 n++;
			end
			chk({13'h0000, done, xch}, 16'h0005);
			@(posedge i_core_clk);
			#1 chk(16'(i_dcpa_periph_model.nrd - r0), {15'h0000, e[17] & !e[16]});
			chk(16'(i_dcpa_periph_model.nwr - w0), {15'h0000, e[17] & e[16]});
			if (e[16] && e[17]) begin
				chk(i_dcpa_periph_model.last_addr_r, e[15:0]);
				chk(i_dcpa_periph_model.last_data_r, e[15:0]);
			end
			if (!e[16]) rd(4'h7, e[17] ? ~e[15:0] : 16'h0000);
		end
		$display("t_assoc done");
	endtask : t_assoc
	task automatic t_shared;
		wr(4'h0, 16'h003C);
		wr(4'h1, 16'h0290);
		wr(4'h2, 16'h0001);
		wr(4'h8, 16'h003C);
		wr(4'h9, 16'h0298);
		wr(4'hB, 16'hBEEF);
		wr(4'hA, 16'h0003);
		i_dcpa_periph_model.fire(7);
		#1 chk({12'h000, pend}, 16'h0005);
		grant(2'h0, 4'h4);
		grant(2'h2, 4'h0);
		@(posedge i_core_clk);
		#1 chk(i_dcpa_periph_model.last_data_r, 16'hBEEF);
		$display("t_shared done");
	endtask : t_shared
	task automatic t_manual;
		wr(4'hA, 16'h0000);
		wr(4'hC, 16'h0007);
		wr(4'hD, 16'h0300);
		wr(4'hE, 16'h0001);
		fork
			wr(4'hE, 16'h0005);
			i_dcpa_periph_model.fire(7);
		join
		#1 chk({12'h000, pend}, 16'h0009);
		grant(2'h0, 4'h8);
		grant(2'h3, 4'h0);
		rd(4'hF, 16'hFCFF);
		$display("t_manual done");
	endtask : t_manual
	task automatic t_unlisted;
		int n0;
		wr(4'h0, 16'h0007);
		wr(4'h4, 16'h0007);
		n0 = ndone;
		for (int n = 0; n < 11; n++) i_dcpa_periph_model.fire(n);
		repeat (8) @(posedge i_core_clk);
		#1 chk(16'(ndone - n0), 16'h0000);
		$display("t_unlisted done");
	endtask : t_unlisted
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	// main sequence after ten cycles of reset
	initial begin
		repeat (10) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		t_regs();
		t_assoc();
		t_shared();
		t_manual();
		t_unlisted();
		final_report();
	end
	// watchdog, about thirty times the expected run
	initial begin
		#100000;
		miscompares++;
		final_report();
	end
endmodule : dcpa_tb_top
